// file: ppc_pkg.sv
// Package of constants for the peripheral port configuration block
`default_nettype none
package ppc_pkg;
  // ----------------------------------------------------------------
  // Configuration byte indices on the load port
  // ----------------------------------------------------------------
  localparam logic [4:0] PPC_IDX_MODEM_MASK = 5'h06;
  localparam logic [4:0] PPC_IDX_MISC = 5'h07;
  localparam logic [4:0] PPC_IDX_GLOBAL = 5'h08;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PPC_RST_MODEM_MASK = 8'h03;
  localparam logic [7:0] PPC_RST_MISC = 8'h80;
  localparam logic [7:0] PPC_RST_GLOBAL = 8'h00;
  // ----------------------------------------------------------------
  // Misc byte field positions
  // ----------------------------------------------------------------
  localparam int PPC_MISC_ALT_CD_B7_DIS = 0;
  localparam int PPC_MISC_RD_DATA_DIS = 1;
  localparam int PPC_MISC_HW_VOL_EN = 2;
  localparam int PPC_MISC_MODEM_POL = 3;
  localparam int PPC_MISC_VENDOR_KEY_DIS = 4;
  localparam int PPC_MISC_PNP_KEY_DIS = 5;
  localparam int PPC_MISC_SYNTH_POL = 6;
  localparam int PPC_MISC_CD_POL = 7;
  // ----------------------------------------------------------------
  // Global byte field positions
  // ----------------------------------------------------------------
  localparam int PPC_GLB_DSP_SWITCH = 2;
  localparam int PPC_GLB_WT_EN = 3;
  localparam int PPC_GLB_ALT_LINE_DIS = 4;
  localparam int PPC_GLB_VOL_FMT_LO = 5;
  localparam int PPC_GLB_VOL_FMT_HI = 6;
  localparam int PPC_GLB_INT_FM_EN = 7;
  // ----------------------------------------------------------------
  // Peripheral port address width
  // ----------------------------------------------------------------
  localparam int PPC_PORT_ADDR_W = 3;
endpackage
`default_nettype wire

// file: ppc_config.sv
// Peripheral port hardware configuration bytes and their effects
`default_nettype none
// Overview of operation
// [RULE1] Modem select covers 1..256 bytes by contiguous low ones mask; others reserved.
// [RULE2] Only three low address bits reach the port; board buffers upper bits.
// [RULE3] Alt CD bit7 disable floats host data bit 7 on reads of base+1 only.
// [RULE4] Read data disable floats all host data on peripheral reads, decode kept.
// [RULE5] Read data disable forced on by wavetable enable or DSP switch, any source.
// [RULE6] Volume enable makes up, down, mute pins active; otherwise ignored.
// [RULE7] Modem polarity flag set means modem interrupt active high, else low.
// [RULE8] Vendor key disable makes the vendor key sequence ignored.
// [RULE9] PnP key disable ignores PnP key; both disables lock reconfiguration.
// [RULE10] Synth polarity flag set means synth interrupt active high, else low.
// [RULE11] CD polarity flag set means CD interrupt active high, else low.
// [RULE12] Supplier writes zero to the two lowest global reserved bits.
// [RULE13] DSP switch moves serial port to data pins 4..1, active with activate bit.
// [RULE14] DSP switch set stops host data drive on peripheral accesses.
// [RULE15] Global byte defaults to all zeros.
// [RULE16] Wavetable enable turns data pins 7..5 into serial port, stops host drive.
// [RULE17] Bytes latch on load and steer pins until the next load.
module ppc_config
  import ppc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Configuration load and readback
  input wire logic cfg_load_i,
  input wire logic [4:0] cfg_index_i,
  input wire logic [7:0] cfg_data_i,
  input wire logic [4:0] cfg_rd_index_i,
  output logic [7:0] cfg_rdata_o,
  // Control register overrides
  input wire logic ctrl_wavetable_port_enable_i,
  input wire logic ctrl_dsp_port_switch_i,
  input wire logic dsp_serial_activate_i,
  // Host bus
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [ADDR_W-1:0] modem_base_address_i,
  input wire logic [ADDR_W-1:0] alt_cd_base_address_i,
  input wire logic synth_hit_i,
  input wire logic cd_hit_i,
  input wire logic [7:0] periph_rdata_i,
  output logic [7:0] host_data_bus_o,
  output logic [7:0] host_data_bus_oe_n_o,
  // Peripheral port
  output logic modem_chip_select_n_o,
  output logic alt_cd_hit_o,
  output logic [PPC_PORT_ADDR_W-1:0] periph_addr_o,
  output logic modem_mask_reserved_o,
  // Interrupts from peripherals
  input wire logic modem_interrupt_in_i,
  input wire logic synth_interrupt_in_i,
  input wire logic cd_interrupt_in_i,
  output logic modem_irq_o,
  output logic synth_irq_o,
  output logic cd_irq_o,
  // Configuration keys
  input wire logic vendor_key_seen_i,
  input wire logic pnp_key_seen_i,
  output logic vendor_key_accept_o,
  output logic pnp_key_accept_o,
  output logic reconfig_locked_o,
  // Hardware volume pins
  input wire logic vol_up_i,
  input wire logic vol_down_i,
  input wire logic vol_mute_i,
  output logic vol_up_o,
  output logic vol_down_o,
  output logic vol_mute_o,
  output logic [1:0] volume_format_o,
  // Pin function selection
  output logic dsp_on_periph_pins_o,
  output logic dsp_serial_pins_low_o,
  output logic wavetable_pins_high_o,
  output logic internal_fm_enable_o,
  output logic synth_alt_line_disable_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mask is a contiguous run of ones from bit 0 (including all zeros)
  function automatic logic mask_ok(input logic [7:0] m);
    logic [8:0] sum;
    sum = {1'b0, m} + 9'h001;
    mask_ok = ((sum & {1'b0, m}) == 9'h000);
  endfunction

  // Interrupt level to active-high form
  function automatic logic irq_norm(input logic lvl, input logic high_act);
    irq_norm = high_act ? lvl : ~lvl;
  endfunction

  // ----------------------------------------------------------------
  // Configuration bytes
  // ----------------------------------------------------------------
  logic [7:0] modem_decode_mask_byte;
  logic [7:0] misc_config_byte;
  logic [7:0] global_config_byte;
  logic [7:0] next_modem_decode_mask_byte;
  logic [7:0] next_misc_config_byte;
  logic [7:0] next_global_config_byte;

  always_comb begin
    next_modem_decode_mask_byte = modem_decode_mask_byte;
    next_misc_config_byte = misc_config_byte;
    next_global_config_byte = global_config_byte;
    if (cfg_load_i) begin // see [RULE17]
      unique case (cfg_index_i)
        PPC_IDX_MODEM_MASK: next_modem_decode_mask_byte = cfg_data_i;
        PPC_IDX_MISC: next_misc_config_byte = cfg_data_i;
        PPC_IDX_GLOBAL: next_global_config_byte = cfg_data_i; // see [RULE12]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      modem_decode_mask_byte <= PPC_RST_MODEM_MASK;
      misc_config_byte <= PPC_RST_MISC;
      global_config_byte <= PPC_RST_GLOBAL; // see [RULE15]
    end else begin
      modem_decode_mask_byte <= next_modem_decode_mask_byte;
      misc_config_byte <= next_misc_config_byte;
      global_config_byte <= next_global_config_byte;
    end
  end

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  logic wt_en;
  logic dsp_sw;
  logic rd_dis;
  logic modem_hit;
  logic alt_cd_plus1;
  logic periph_hit;
  logic [ADDR_W-1:0] mask_ext;

  always_comb begin
    wt_en = global_config_byte[PPC_GLB_WT_EN] | ctrl_wavetable_port_enable_i;
    dsp_sw = global_config_byte[PPC_GLB_DSP_SWITCH] | ctrl_dsp_port_switch_i;
    rd_dis = misc_config_byte[PPC_MISC_RD_DATA_DIS] | wt_en | dsp_sw; // see [RULE5]
    mask_ext = {{(ADDR_W-8){1'b0}}, modem_decode_mask_byte};
    modem_hit = mask_ok(modem_decode_mask_byte)
      && (((host_addr_i ^ modem_base_address_i) & ~mask_ext) == '0); // see [RULE1]
    alt_cd_plus1 = (host_addr_i == (alt_cd_base_address_i + ADDR_W'(1)));
    periph_hit = modem_hit | synth_hit_i | cd_hit_i | alt_cd_plus1;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [7:0] next_host_data;
  logic [7:0] next_oe_n;
  logic next_mcs_n;
  logic next_alt_cd_hit;
  logic [PPC_PORT_ADDR_W-1:0] next_paddr;
  logic next_modem_irq;
  logic next_synth_irq;
  logic next_cd_irq;
  logic next_vkey;
  logic next_pkey;
  logic [2:0] next_vol;

  always_comb begin
    next_host_data = periph_rdata_i;
    next_oe_n = 8'hFF;
    if (host_rd_i && periph_hit) begin
      next_oe_n = 8'h00;
      if (rd_dis) begin
        next_oe_n = 8'hFF; // see [RULE4] [RULE14] [RULE16]
      end else if (alt_cd_plus1 && misc_config_byte[PPC_MISC_ALT_CD_B7_DIS]) begin
        next_oe_n[7] = 1'b1; // see [RULE3]
      end
    end
    next_mcs_n = ~(modem_hit && (host_rd_i || host_wr_i)); // see [RULE1]
    next_alt_cd_hit = alt_cd_plus1;
    next_paddr = host_addr_i[PPC_PORT_ADDR_W-1:0]; // see [RULE2]
    next_modem_irq = irq_norm(modem_interrupt_in_i,
      misc_config_byte[PPC_MISC_MODEM_POL]); // see [RULE7]
    next_synth_irq = irq_norm(synth_interrupt_in_i,
      misc_config_byte[PPC_MISC_SYNTH_POL]); // see [RULE10]
    next_cd_irq = irq_norm(cd_interrupt_in_i,
      misc_config_byte[PPC_MISC_CD_POL]); // see [RULE11]
    next_vkey = vendor_key_seen_i & ~misc_config_byte[PPC_MISC_VENDOR_KEY_DIS]; // see [RULE8]
    next_pkey = pnp_key_seen_i & ~misc_config_byte[PPC_MISC_PNP_KEY_DIS]; // see [RULE9]
    next_vol = misc_config_byte[PPC_MISC_HW_VOL_EN]
      ? {vol_mute_i, vol_down_i, vol_up_i} : 3'h0; // see [RULE6]
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_data_bus_o <= 8'h00;
      host_data_bus_oe_n_o <= 8'hFF;
      modem_chip_select_n_o <= 1'b1;
      alt_cd_hit_o <= 1'b0;
      periph_addr_o <= '0;
      modem_irq_o <= 1'b0;
      synth_irq_o <= 1'b0;
      cd_irq_o <= 1'b0;
      vendor_key_accept_o <= 1'b0;
      pnp_key_accept_o <= 1'b0;
      {vol_mute_o, vol_down_o, vol_up_o} <= 3'h0;
    end else begin
      host_data_bus_o <= next_host_data;
      host_data_bus_oe_n_o <= next_oe_n;
      modem_chip_select_n_o <= next_mcs_n;
      alt_cd_hit_o <= next_alt_cd_hit;
      periph_addr_o <= next_paddr;
      modem_irq_o <= next_modem_irq;
      synth_irq_o <= next_synth_irq;
      cd_irq_o <= next_cd_irq;
      vendor_key_accept_o <= next_vkey;
      pnp_key_accept_o <= next_pkey;
      {vol_mute_o, vol_down_o, vol_up_o} <= next_vol;
    end
  end

  // ----------------------------------------------------------------
  // Static configuration outputs
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cfg_rd_index_i)
      PPC_IDX_MODEM_MASK: cfg_rdata_o = modem_decode_mask_byte;
      PPC_IDX_MISC: cfg_rdata_o = misc_config_byte;
      PPC_IDX_GLOBAL: cfg_rdata_o = global_config_byte;
      default: cfg_rdata_o = 8'h00;
    endcase
  end

  assign modem_mask_reserved_o = ~mask_ok(modem_decode_mask_byte); // see [RULE1]
  assign reconfig_locked_o = misc_config_byte[PPC_MISC_VENDOR_KEY_DIS]
    & misc_config_byte[PPC_MISC_PNP_KEY_DIS]; // see [RULE9]
  assign dsp_on_periph_pins_o = dsp_sw; // see [RULE13]
  assign dsp_serial_pins_low_o = dsp_sw & dsp_serial_activate_i; // see [RULE13]
  assign wavetable_pins_high_o = wt_en; // see [RULE16]
  assign volume_format_o = {global_config_byte[PPC_GLB_VOL_FMT_HI],
    global_config_byte[PPC_GLB_VOL_FMT_LO]};
  assign internal_fm_enable_o = global_config_byte[PPC_GLB_INT_FM_EN];
  assign synth_alt_line_disable_o = global_config_byte[PPC_GLB_ALT_LINE_DIS];

endmodule // ppc_config
`default_nettype wire

// file: ppc_periph_model.sv
// Model of the modem, CD and synthesizer peripherals
`default_nettype none
module ppc_periph_model (
  // Port address and interrupt requests
  input wire logic [2:0] addr_i,
  input wire logic [2:0] req_i,
  input wire logic [2:0] pol_i,
  // Read data and interrupt pins
  output logic [7:0] rdata_o,
  output logic [2:0] int_o
);
  assign rdata_o = {5'h15, addr_i};
  assign int_o = req_i ~^ pol_i;
endmodule // ppc_periph_model
`default_nettype wire

// file: ppc_config_properties.sv
// Assertion checker for the peripheral port configuration block
`default_nettype none
module ppc_config_properties
  import ppc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock, reset and load port
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cfg_load_i,
  input wire logic [4:0] cfg_index_i,
  input wire logic [7:0] cfg_data_i,
  // Host side
  input wire logic ctrl_wavetable_port_enable_i,
  input wire logic ctrl_dsp_port_switch_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [ADDR_W-1:0] modem_base_address_i,
  input wire logic [ADDR_W-1:0] alt_cd_base_address_i,
  input wire logic [7:0] host_data_bus_oe_n_o,
  input wire logic modem_chip_select_n_o,
  input wire logic modem_mask_reserved_o,
  // Interrupt, key and volume
  input wire logic modem_interrupt_in_i,
  input wire logic modem_irq_o,
  input wire logic vendor_key_seen_i,
  input wire logic vendor_key_accept_o,
  input wire logic reconfig_locked_o,
  input wire logic vol_up_o
);
  logic [7:0] mask, misc, glb;
  logic contig, dis, b7, mhit;
  assign contig = (mask & (mask + 8'h01)) == 8'h00;
  assign dis = misc[1] | glb[2] | glb[3]
    | ctrl_wavetable_port_enable_i | ctrl_dsp_port_switch_i;
  assign b7 = host_rd_i && !dis && misc[0] && host_addr_i == alt_cd_base_address_i + 1'b1;
  assign mhit = (host_rd_i || host_wr_i) && contig
    && ((host_addr_i ^ modem_base_address_i) & ~ADDR_W'(mask)) == '0;
  // Shadow copies of the bytes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask <= PPC_RST_MODEM_MASK;
      misc <= PPC_RST_MISC;
      glb <= PPC_RST_GLOBAL;
    end else if (cfg_load_i) begin
      if (cfg_index_i == PPC_IDX_MODEM_MASK) mask <= cfg_data_i;
      if (cfg_index_i == PPC_IDX_MISC) misc <= cfg_data_i;
      if (cfg_index_i == PPC_IDX_GLOBAL) glb <= cfg_data_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_modem_select: assert property (
    $past(reset_n_i) |-> modem_chip_select_n_o == !$past(mhit))
    else $error("modem select wrong");
  a_mask_reserved: assert property (modem_mask_reserved_o == !contig)
    else $error("mask reserved flag wrong");
  a_bit7_float: assert property (
    $past(reset_n_i) && $past(b7) |-> host_data_bus_oe_n_o == 8'h80)
    else $error("bit 7 not floated");
  a_read_disable: assert property (
    $past(reset_n_i) && $past(host_rd_i) && $past(dis) |-> host_data_bus_oe_n_o == 8'hFF)
    else $error("host data driven");
  a_volume_gate: assert property (!$past(misc[2]) |-> !vol_up_o)
    else $error("volume pin not gated");
  a_modem_pol: assert property (
    $past(reset_n_i) |-> modem_irq_o == ($past(modem_interrupt_in_i) == $past(misc[3])))
    else $error("modem irq");
  a_vendor_key: assert property (
    vendor_key_accept_o |-> $past(vendor_key_seen_i) && !$past(misc[4]))
    else $error("vendor key accepted");
  a_lock_state: assert property (reconfig_locked_o == (misc[4] && misc[5]))
    else $error("lock flag wrong");
endmodule // ppc_config_properties
bind ppc_config ppc_config_properties #(.ADDR_W(ADDR_W)) i_props (.*);
`default_nettype wire

// file: tb_top.sv
// Testbench for the peripheral port configuration block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] mb = 16'h0300;
  localparam logic [15:0] ab = 16'h0170;
  logic clk_i, reset_n_i, load, rd, wr, wt, dsp, act, vs, ps, vu, vd, vm, sh, ch;
  logic mcs_n, rsv, mi, si, ci, va, pa, lk, vuo, vdo, vmo, dlow, ach, dop, wph, internal_fm_enable, synth_alt_line_disable;
  logic [1:0] vfmt;
  logic [4:0] idx, rd_idx;
  logic [7:0] data, rdata, oe_n, prd, hd;
  logic [15:0] addr;
  logic [2:0] req, pol, pint, pa3;
  int errors, num_checks, cycles;
  ppc_config i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_load_i(load), .cfg_index_i(idx),
    .cfg_data_i(data), .cfg_rd_index_i(rd_idx), .cfg_rdata_o(rdata),
    .ctrl_wavetable_port_enable_i(wt), .ctrl_dsp_port_switch_i(dsp),
    .dsp_serial_activate_i(act), .host_addr_i(addr), .host_rd_i(rd), .host_wr_i(wr),
    .modem_base_address_i(mb), .alt_cd_base_address_i(ab), .synth_hit_i(sh),
    .cd_hit_i(ch), .periph_rdata_i(prd), .host_data_bus_o(hd), .host_data_bus_oe_n_o(oe_n),
    .modem_chip_select_n_o(mcs_n), .alt_cd_hit_o(ach), .periph_addr_o(pa3),
    .modem_mask_reserved_o(rsv), .modem_interrupt_in_i(pint[0]),
    .synth_interrupt_in_i(pint[1]), .cd_interrupt_in_i(pint[2]), .modem_irq_o(mi),
    .synth_irq_o(si), .cd_irq_o(ci), .vendor_key_seen_i(vs), .pnp_key_seen_i(ps),
    .vendor_key_accept_o(va), .pnp_key_accept_o(pa), .reconfig_locked_o(lk),
    .vol_up_i(vu), .vol_down_i(vd), .vol_mute_i(vm), .vol_up_o(vuo), .vol_down_o(vdo),
    .vol_mute_o(vmo), .volume_format_o(vfmt), .dsp_on_periph_pins_o(dop),
    .dsp_serial_pins_low_o(dlow), .wavetable_pins_high_o(wph), .internal_fm_enable_o(internal_fm_enable),
    .synth_alt_line_disable_o(synth_alt_line_disable));
  ppc_periph_model i_model (.addr_i(pa3), .req_i(req), .pol_i(pol), .rdata_o(prd), .int_o(pint));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic ld(input logic [4:0] i, input logic [7:0] d);
    idx = i;
    data = d;
    load = 1;
    tick;
    load = 0;
    tick;
  endtask
  task automatic hc(input logic [15:0] a, input logic r, input logic w);
    addr = a;
    rd = r;
    wr = w;
    tick;
  endtask
  task automatic end_of_test;
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset;
    rd_idx = 5'h06;
    #1 chk(rdata, 8'h03);
    tick;
    rd_idx = 5'h07;
    #1 chk({oe_n, mcs_n, rdata}, {9'h1FF, 8'h80});
    tick;
    rd_idx = 5'h08;
    #1 chk(rdata, 8'h00);
    tick;
  endtask
  task automatic t_modem;
    for (int i = 0; i <= 8; i++) begin
      ld(5'h06, 8'((16'h1 << i) - 1));
      hc(mb + 16'((16'h1 << i) - 1), 1, 0);
      chk(mcs_n, 0);
      hc(mb + 16'(16'h1 << i), 0, 1);
      chk(mcs_n, 1);
    end
    ld(5'h06, 8'h05);
    hc(mb, 1, 0);
    chk({mcs_n, rsv}, 2'b11);
    ld(5'h06, 8'h03);
  endtask
  task automatic t_drive;
    ld(5'h07, 8'h01);
    hc(ab + 16'h1, 1, 0);
    chk({ach, pa3, oe_n}, {1'b1, 3'h1, 8'h80});
    hc(mb, 1, 0);
    chk({ach, hd, oe_n}, {1'b0, 8'hA9, 8'h00});
    ld(5'h07, 8'h02);
    chk({oe_n, mcs_n}, 9'h1FE);
    sh = 1;
    hc(16'h0001, 1, 0);
    chk({oe_n, mcs_n}, 9'h1FF);
    ld(5'h07, 8'h00);
    chk(oe_n, 8'h00);
    sh = 0;
    ch = 1;
    tick;
    chk(oe_n, 8'h00);
    ld(5'h08, 8'h08);
    chk({wph, dop, oe_n}, {2'b10, 8'hFF});
    ld(5'h08, 8'h04);
    chk({wph, dop, oe_n}, {2'b01, 8'hFF});
    ld(5'h08, 8'h00);
    wt = 1;
    tick;
    chk({wph, oe_n}, {1'b1, 8'hFF});
    wt = 0;
    dsp = 1;
    tick;
    chk({dop, oe_n}, {1'b1, 8'hFF});
    dsp = 0;
    tick;
    chk(oe_n, 8'h00);
    ch = 0;
    hc(16'h0, 0, 0);
  endtask
  task automatic t_irq;
    for (int p = 0; p < 2; p++) begin
      ld(5'h07, p ? 8'hC8 : 8'h00);
      pol = {3{p[0]}};
      for (int r = 0; r < 2; r++) begin
        req = {3{r[0]}};
        tick;
        tick;
        chk({mi, si, ci}, {3{r[0]}});
      end
    end
  endtask
  task automatic t_keys;
    vu = 1;
    vd = 1;
    ld(5'h07, 8'h00);
    chk({vuo, vdo, vmo}, 3'b000);
    ld(5'h07, 8'h04);
    chk({vuo, vdo, vmo}, 3'b110);
    vu = 0;
    vm = 1;
    tick;
    chk({vuo, vdo, vmo}, 3'b011);
    ld(5'h07, 8'h30);
    vs = 1;
    ps = 1;
    tick;
    chk({va, pa, lk}, 3'b001);
    ld(5'h07, 8'h00);
    chk({va, pa, lk}, 3'b110);
    vs = 0;
    ps = 0;
    ld(5'h08, 8'h04);
    chk(dlow, 0);
    act = 1;
    #1 chk(dlow, 1);
    tick;
    ld(5'h08, 8'hA0);
    ld(5'h09, 8'h55);
    chk({rdata, internal_fm_enable, vfmt, synth_alt_line_disable}, {8'hA0, 1'b1, 2'b01, 1'b0});
  endtask
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    {reset_n_i, load, rd, wr, wt, dsp, act, vs, ps, vu, vd, vm, sh, ch} = '0;
    {idx, rd_idx, data, addr, req, pol} = '0;
    repeat (20) @(posedge clk_i);
    #1 reset_n_i = 1;
    t_reset;
    t_modem;
    t_drive;
    t_irq;
    t_keys;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
